// ===== hdl/ecsc_pkg.sv
package ecsc_pkg;
  // Register byte addresses
  localparam logic [11:0] ECSC_CTRL_ADDR = 12'h050;
  localparam logic [11:0] ECSC_IRQ_STAT_ADDR = 12'h054;
  localparam logic [11:0] ECSC_IRQ_MASK_ADDR = 12'h058;
  // Field positions in the clock source control word
  localparam int ECSC_CLEANER_LOCK_POS = 31;
  localparam int ECSC_BW_LSB = 28;
  localparam int ECSC_SRC_LSB = 24;
  localparam int ECSC_PHASE_POS = 23;
  localparam int ECSC_DIV_LSB = 16;
  localparam int ECSC_SYNTH_LOCK_POS = 9;
  // Values after reset
  localparam logic [2:0] ECSC_BW_RST = 3'h0;
  localparam logic [2:0] ECSC_SRC_RST = 3'h0;
  localparam logic [5:0] ECSC_DIV_RST = 6'h00;
  localparam logic [3:0] ECSC_MASK_RST = 4'h0;
  // Highest legal codes, and the divider code that turns the divider off
  localparam logic [2:0] ECSC_BW_MAX = 3'h4;
  localparam logic [5:0] ECSC_DIV_MAX = 6'h1F;
  localparam logic [5:0] ECSC_DIV_OFF = 6'h0C;
  // Event bits of the interrupt status register
  localparam int ECSC_EV_CLEAN_LOST = 0;
  localparam int ECSC_EV_CLEAN_GOT = 1;
  localparam int ECSC_EV_SYNTH_LOST = 2;
  localparam int ECSC_EV_SRC_CHG = 3;

  // Reference source codes
  typedef enum logic [2:0] {
    ECSC_SRC_SYNTH = 3'h0,
    ECSC_SRC_RF = 3'h1,
    ECSC_SRC_BP100 = 3'h2,
    ECSC_SRC_RSVD = 3'h3,
    ECSC_SRC_RECOV = 3'h4,
    ECSC_SRC_SPLIT = 3'h5,
    ECSC_SRC_BP10 = 3'h6,
    ECSC_SRC_DECIM = 3'h7
  } ecsc_src_t;

  // Conditioning settings sent to the clock tree
  typedef struct packed {
    logic [2:0] loop_bandwidth_code;
    logic [5:0] rf_divide_ratio_m1;
    logic rf_divider_off;
    ecsc_src_t reference_source_code;
    logic [7:0] src_onehot;
    logic fanout_mode;
    logic rate_down_convert;
    logic decimate_mode;
    logic use_multiplier;
    logic bus_phase_flip;
  } ecsc_clk_cfg_t;

  // Wishbone slave request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } ecsc_wb_req_t;

  // Wishbone slave answer
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ecsc_wb_rsp_t;
endpackage

// ===== hdl/ecsc_top.sv
`timescale 1ns/100ps
// Functional notes
// - Drive three-bit loop bandwidth code; 000 lowest through 100 highest.
// - Divider code n in 0..31 divides RF by n+1; code 12 turns it off.
// - Source 000 selects the internal fractional synthesizer.
// - Source 001 selects front-panel RF after the divider.
// - Source 010 selects 100 MHz backplane; 110 selects multiplied 10 MHz.
// - Source 100 runs from recovered receive clock in fan-out mode.
// - Source 101: RF downstream, internal upstream, fan-out, rate down-conversion.
// - Source 111 uses recovered clock halved, decimate mode.
// - Writable bit flips distributed bus phase against the event clock.
// - Cleaner lock reads at bit 31, synthesizer lock at bit 9.
module ecsc_top
  import ecsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ecsc_wb_req_t wb_req_i,
  output ecsc_wb_rsp_t wb_rsp_o,
  input wire logic cleaner_lock_flag_i,
  input wire logic synth_ref_lock_flag_i,
  output ecsc_clk_cfg_t clk_cfg_o,
  output logic irq_o
);

  // Whole module state
  typedef struct packed {
    logic [1:0] clean_sync;
    logic [1:0] synth_sync;
    logic clean_prev;
    logic synth_prev;
    logic [2:0] bw;
    ecsc_src_t src;
    logic [5:0] div;
    logic phase;
    logic [3:0] status;
    logic [3:0] mask;
    ecsc_wb_rsp_t rsp;
    ecsc_clk_cfg_t cfg;
  } ecsc_state_t;

  ecsc_state_t cur;
  ecsc_state_t next_cur;

  // Decode of a source code into its one-hot selection
  function automatic logic [7:0] ecsc_onehot(input ecsc_src_t s);
    logic [7:0] v;
    v = 8'h00;
    v[s] = 1'b1;
    return v;
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] ecsc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] ctrl_word;
  logic [31:0] wr_word;
  logic req;
  logic [3:0] events;

  // Next state
  always_comb
  begin
    next_cur = cur;
    wr_word = 32'h0000_0000;
    // Lock inputs are asynchronous: two stages before use
    next_cur.clean_sync = {cur.clean_sync[0], cleaner_lock_flag_i};
    next_cur.synth_sync = {cur.synth_sync[0], synth_ref_lock_flag_i};
    next_cur.clean_prev = cur.clean_sync[1];
    next_cur.synth_prev = cur.synth_sync[1];
    // Readback word: lock bits from synchronised status
    ctrl_word = 32'h0000_0000;
    ctrl_word[ECSC_CLEANER_LOCK_POS] = cur.clean_sync[1];
    ctrl_word[ECSC_BW_LSB +: 3] = cur.bw;
    ctrl_word[ECSC_SRC_LSB +: 3] = cur.src;
    ctrl_word[ECSC_PHASE_POS] = cur.phase;
    ctrl_word[ECSC_DIV_LSB +: 6] = cur.div;
    ctrl_word[ECSC_SYNTH_LOCK_POS] = cur.synth_sync[1];
    req = wb_req_i.cyc && wb_req_i.stb && !cur.rsp.ack;
    events = 4'h0;
    events[ECSC_EV_CLEAN_LOST] = cur.clean_prev && !cur.clean_sync[1];
    events[ECSC_EV_CLEAN_GOT] = !cur.clean_prev && cur.clean_sync[1];
    events[ECSC_EV_SYNTH_LOST] = cur.synth_prev && !cur.synth_sync[1];
    next_cur.rsp.ack = req;
    next_cur.rsp.dat = 32'h0000_0000;
    if (req && wb_req_i.we && wb_req_i.adr == ECSC_CTRL_ADDR)
    begin
      wr_word = ecsc_merge(ctrl_word, wb_req_i.dat, wb_req_i.sel);
      // Out-of-range bandwidth codes are held back
      if (wr_word[ECSC_BW_LSB +: 3] <= ECSC_BW_MAX)
      begin
        next_cur.bw = wr_word[ECSC_BW_LSB +: 3];
      end
      // Reserved source code leaves the selection alone
      if (wr_word[ECSC_SRC_LSB +: 3] != ECSC_SRC_RSVD)
      begin
        next_cur.src = ecsc_src_t'(wr_word[ECSC_SRC_LSB +: 3]);
        // Flags that software must reload the synthesizer word
        events[ECSC_EV_SRC_CHG] = wr_word[ECSC_SRC_LSB +: 3] != cur.src;
      end
      next_cur.phase = wr_word[ECSC_PHASE_POS];
      next_cur.div = wr_word[ECSC_DIV_LSB +: 6];
    end
    if (req && wb_req_i.we && wb_req_i.adr == ECSC_IRQ_MASK_ADDR && wb_req_i.sel[0])
    begin
      next_cur.mask = wb_req_i.dat[3:0];
    end
    // Read data, status cleared by its own read
    if (req && !wb_req_i.we)
    begin
      unique case (wb_req_i.adr)
        ECSC_CTRL_ADDR: next_cur.rsp.dat = ctrl_word;
        ECSC_IRQ_STAT_ADDR: next_cur.rsp.dat = {28'h0000000, cur.status};
        ECSC_IRQ_MASK_ADDR: next_cur.rsp.dat = {28'h0000000, cur.mask};
        default: next_cur.rsp.dat = 32'h0000_0000;
      endcase
    end
    if (req && !wb_req_i.we && wb_req_i.adr == ECSC_IRQ_STAT_ADDR)
    begin
      next_cur.status = events; // set wins over clear
    end
    else
    begin
      next_cur.status = cur.status | events;
    end
    // Clock tree settings
    next_cur.cfg.loop_bandwidth_code = cur.bw;
    next_cur.cfg.rf_divider_off = cur.div == ECSC_DIV_OFF || cur.div > ECSC_DIV_MAX;
    next_cur.cfg.rf_divide_ratio_m1 = cur.div;
    next_cur.cfg.reference_source_code = cur.src;
    next_cur.cfg.src_onehot = ecsc_onehot(cur.src);
    next_cur.cfg.fanout_mode = cur.src == ECSC_SRC_RECOV || cur.src == ECSC_SRC_SPLIT;
    next_cur.cfg.rate_down_convert = cur.src == ECSC_SRC_SPLIT;
    next_cur.cfg.decimate_mode = cur.src == ECSC_SRC_DECIM;
    next_cur.cfg.use_multiplier = cur.src == ECSC_SRC_BP10;
    next_cur.cfg.bus_phase_flip = cur.phase;
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur <= '0;
      cur.bw <= ECSC_BW_RST;
      cur.src <= ecsc_src_t'(ECSC_SRC_RST);
      cur.div <= ECSC_DIV_RST;
      cur.mask <= ECSC_MASK_RST;
      cur.cfg.src_onehot <= 8'h01;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign wb_rsp_o = cur.rsp;
  assign clk_cfg_o = cur.cfg;
  assign irq_o = |(cur.status & cur.mask);

  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bw_range_a: assert property (clk_cfg_o.loop_bandwidth_code <= 3'h4)
    else $error("bandwidth code beyond highest");
  div_off_a: assert property (cur.div == 6'h0C |=> clk_cfg_o.rf_divider_off)
    else $error("divider code 12 not off");
  div_on_a: assert property (cur.div == 6'h0B |=> !clk_cfg_o.rf_divider_off)
    else $error("divider wrongly off");
  synth_sel_a: assert property (cur.src == ECSC_SRC_SYNTH |=> clk_cfg_o.src_onehot == 8'h01)
    else $error("synth not selected");
  rf_sel_a: assert property (cur.src == ECSC_SRC_RF |=> clk_cfg_o.src_onehot == 8'h02)
    else $error("rf not selected");
  mult_sel_a: assert property (cur.src == ECSC_SRC_BP10 |=> clk_cfg_o.use_multiplier)
    else $error("multiplier not used");
  fanout_a: assert property (cur.src == ECSC_SRC_RECOV |=> clk_cfg_o.fanout_mode)
    else $error("fan-out missing");
  split_a: assert property (cur.src == ECSC_SRC_SPLIT |=> clk_cfg_o.rate_down_convert)
    else $error("down-conversion missing");
  decim_a: assert property (cur.src == ECSC_SRC_DECIM |=> clk_cfg_o.decimate_mode)
    else $error("decimate missing");
  phase_wr_a: assert property (req && wb_req_i.we && wb_req_i.adr == 12'h050
    && wb_req_i.sel[2] |=> cur.phase == $past(wb_req_i.dat[23]) ##1
    clk_cfg_o.bus_phase_flip == $past(cur.phase))
    else $error("phase bit not applied");
  lock_read_a: assert property (req && !wb_req_i.we && wb_req_i.adr == 12'h050
    |=> wb_rsp_o.ack && wb_rsp_o.dat[31] == $past(cur.clean_sync[1]))
    else $error("lock readback wrong");
  rsvd_src_a: assert property (req && wb_req_i.we && wb_req_i.adr == 12'h050
    && wb_req_i.sel[3] && wb_req_i.dat[26:24] == 3'h3 |=> $stable(cur.src))
    else $error("reserved source taken");

  // Out-of-range bandwidth write keeps the old code
  bw_hold_a: assert property (req && wb_req_i.we && wb_req_i.adr == ECSC_CTRL_ADDR
    && wb_req_i.sel[3] && wb_req_i.dat[30:28] > 3'h4 |=> $stable(cur.bw))
    else $error("bad bandwidth code taken");
  // Legal bandwidth write lands in the register
  bw_take_a: assert property (req && wb_req_i.we && wb_req_i.adr == ECSC_CTRL_ADDR
    && wb_req_i.sel[3] && wb_req_i.dat[30:28] <= 3'h4 |=> cur.bw == $past(wb_req_i.dat[30:28]))
    else $error("bandwidth code not taken");
  // Bandwidth output follows the register one cycle later
  bw_out_a: assert property (clk_cfg_o.loop_bandwidth_code == $past(cur.bw))
    else $error("bandwidth output stale");

  // Divider write lands in the register
  div_take_a: assert property (req && wb_req_i.we && wb_req_i.adr == ECSC_CTRL_ADDR
    && wb_req_i.sel[2] |=> cur.div == $past(wb_req_i.dat[21:16]))
    else $error("divider code not taken");
  // Ratio output carries the code, ratio being code plus one
  div_ratio_a: assert property (clk_cfg_o.rf_divide_ratio_m1 == $past(cur.div))
    else $error("divider ratio stale");
  // Highest legal code still divides
  div_max_a: assert property (cur.div == 6'h1F |=> !clk_cfg_o.rf_divider_off)
    else $error("divide by 32 switched off");
  // Code zero passes the input through
  div_zero_a: assert property (cur.div == 6'h00 |=> !clk_cfg_o.rf_divider_off)
    else $error("divide by 1 switched off");

  // Legal source write lands in the register
  src_take_a: assert property (req && wb_req_i.we && wb_req_i.adr == ECSC_CTRL_ADDR
    && wb_req_i.sel[3] && wb_req_i.dat[26:24] != 3'h3 |=> cur.src == $past(wb_req_i.dat[26:24]))
    else $error("source code not taken");
  // Source code output follows the register
  src_code_a: assert property (clk_cfg_o.reference_source_code == $past(cur.src))
    else $error("source code output stale");
  // Exactly one clock source is selected at a time
  onehot_a: assert property ($onehot(clk_cfg_o.src_onehot))
    else $error("source selection not one-hot");
  // Reserved write keeps the selection seen by the clock tree
  rsvd_out_a: assert property (req && wb_req_i.we && wb_req_i.adr == ECSC_CTRL_ADDR
    && wb_req_i.sel[3] && wb_req_i.dat[26:24] == 3'h3 |=> ##1 $stable(clk_cfg_o.src_onehot))
    else $error("reserved source reached clock tree");
  // Readback of the source field
  src_read_a: assert property (req && !wb_req_i.we && wb_req_i.adr == ECSC_CTRL_ADDR
    |=> wb_rsp_o.dat[26:24] == $past(cur.src))
    else $error("source readback wrong");

  // 100 MHz backplane taken directly
  bp100_sel_a: assert property (cur.src == ECSC_SRC_BP100
    |=> clk_cfg_o.src_onehot == 8'h04 && !clk_cfg_o.use_multiplier)
    else $error("100 MHz backplane not selected");
  // 10 MHz backplane goes through the multiplier
  bp10_sel_a: assert property (cur.src == ECSC_SRC_BP10
    |=> clk_cfg_o.src_onehot == 8'h40)
    else $error("10 MHz backplane not selected");
  // Multiplier idle for every other source
  mult_only_a: assert property (cur.src != ECSC_SRC_BP10
    |=> !clk_cfg_o.use_multiplier)
    else $error("multiplier used wrongly");
  // Recovered clock, plain fan-out
  recov_sel_a: assert property (cur.src == ECSC_SRC_RECOV
    |=> clk_cfg_o.src_onehot == 8'h10 && !clk_cfg_o.rate_down_convert)
    else $error("recovered clock not selected");
  // Fan-out only for recovered and split sources
  fanout_only_a: assert property (!(cur.src inside {ECSC_SRC_RECOV, ECSC_SRC_SPLIT})
    |=> !clk_cfg_o.fanout_mode)
    else $error("fan-out set wrongly");
  // Split source also fans out
  split_fan_a: assert property (cur.src == ECSC_SRC_SPLIT
    |=> clk_cfg_o.fanout_mode && clk_cfg_o.src_onehot == 8'h20)
    else $error("split source not fanned out");
  // Decimation only on its own source
  decim_only_a: assert property (cur.src != ECSC_SRC_DECIM
    |=> !clk_cfg_o.decimate_mode)
    else $error("decimate set wrongly");

  // Phase output follows the register
  phase_out_a: assert property (clk_cfg_o.bus_phase_flip == $past(cur.phase))
    else $error("phase output stale");
  // Synthesizer lock readback
  synth_read_a: assert property (req && !wb_req_i.we && wb_req_i.adr == ECSC_CTRL_ADDR
    |=> wb_rsp_o.ack && wb_rsp_o.dat[9] == $past(cur.synth_sync[1]))
    else $error("synth lock readback wrong");
  // A real source change raises the reload event
  src_chg_a: assert property (req && wb_req_i.we && wb_req_i.adr == ECSC_CTRL_ADDR
    && wb_req_i.sel[3] && wb_req_i.dat[26:24] != 3'h3 && wb_req_i.dat[26:24] != cur.src
    |=> cur.status[ECSC_EV_SRC_CHG])
    else $error("source change event missing");

  src_change_c: cover property (cur.src == ECSC_SRC_SYNTH ##[1:50] cur.src == ECSC_SRC_RF);
  // Reserved source written
  rsvd_c: cover property (req && wb_req_i.we && wb_req_i.adr == ECSC_CTRL_ADDR
    && wb_req_i.dat[26:24] == 3'h3);
  irq_c: cover property ($rose(irq_o));
  div_off_c: cover property (clk_cfg_o.rf_divider_off);
  decim_c: cover property (clk_cfg_o.decimate_mode);
endmodule

// ===== verification/ecsc_clock_tree_model.sv
`timescale 1ns/100ps
module ecsc_clock_tree_model #(
  parameter int RELOCK = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic drop_i,
  output logic cleaner_lock_flag_o,
  output logic synth_ref_lock_flag_o
);
  logic [7:0] relock_cnt;

  // Both loops lose lock on a drop request and regain it after the relock time
  always_ff @(posedge clk_i)
    if (rst_i || drop_i)
      relock_cnt <= 8'(RELOCK);
    else if (relock_cnt != 8'h00)
      relock_cnt <= relock_cnt - 8'h01;

  // Lock flags are levels, low while acquiring
  assign cleaner_lock_flag_o = (relock_cnt == 8'h00);
  assign synth_ref_lock_flag_o = (relock_cnt == 8'h00);
endmodule

// ===== verification/tb.sv
`timescale 1ns/100ps
module tb
  import ecsc_pkg::*;
;
  logic clk, rst, drop, cl, sl, irq, ph_e;
  ecsc_wb_req_t req;
  ecsc_wb_rsp_t rsp;
  ecsc_clk_cfg_t cfg;
  int num_errors = 0;
  int n_compared = 0;
  logic [32:0] q[$];
  logic [32:0] n;
  logic [2:0] bw_e, src_e;
  logic [5:0] div_e;
  logic [31:0] w;

  ecsc_top ecsc_top_i(.clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_rsp_o(rsp),
    .cleaner_lock_flag_i(cl), .synth_ref_lock_flag_i(sl), .clk_cfg_o(cfg), .irq_o(irq));
  ecsc_clock_tree_model ecsc_clock_tree_model_i(.clk_i(clk), .rst_i(rst), .drop_i(drop),
    .cleaner_lock_flag_o(cl), .synth_ref_lock_flag_o(sl));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Classic single cycle; expected read data is queued before the request
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge clk);
    if (!we)
      q.push_back(e);
    req <= '{1'h1, 1'h1, we, 4'hF, a, d};
    @(posedge clk);
    while (rsp.ack !== 1'h1)
      @(posedge clk);
    req.cyc <= 1'h0;
    req.stb <= 1'h0;
  endtask

  function automatic logic [31:0] ctrl_exp();
    return {cl, bw_e, 1'h0, src_e, ph_e, 1'h0, div_e, 6'h00, sl, 9'h000};
  endfunction

  // Expected conditioning settings; ratio is ignored while the divider is off
  task automatic cfg_chk();
    ecsc_clk_cfg_t e, s;
    e = '0;
    s = cfg;
    e.loop_bandwidth_code = bw_e;
    e.rf_divider_off = (div_e == ECSC_DIV_OFF) || (div_e > ECSC_DIV_MAX);
    e.rf_divide_ratio_m1 = e.rf_divider_off ? 6'h00 : div_e;
    if (e.rf_divider_off)
      s.rf_divide_ratio_m1 = 6'h00;
    e.reference_source_code = ecsc_src_t'(src_e);
    e.src_onehot = 8'h01 << src_e;
    e.fanout_mode = src_e inside {3'h4, 3'h5};
    e.rate_down_convert = (src_e == 3'h5);
    e.decimate_mode = (src_e == 3'h7);
    e.use_multiplier = (src_e == 3'h6);
    e.bus_phase_flip = ph_e;
    chk("clock config", 32'(s), 32'(e));
  endtask

  // Clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Read data monitor takes the oldest note on every read answer
  always @(posedge clk)
    if (rsp.ack === 1'h1 && req.we === 1'h0)
    begin
      n = (q.size() > 0) ? q.pop_front() : 33'h1DEADBEEF;
      if (n[32])
        chk("read data", rsp.dat, n[31:0]);
    end

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    void'($urandom(86203));
    rst = 1'h1;
    drop = 1'h0;
    req = '0;
    {bw_e, src_e, div_e, ph_e} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    cfg_chk();
    chk("irq after reset", 32'(irq), 32'h0);
    repeat (30) @(posedge clk);
    wb(1'h0, ECSC_CTRL_ADDR, 32'h0, {1'h1, ctrl_exp()});
    for (int i = 0; i < 8; i++)
    begin
      w = $urandom;
      w[26:24] = i[2:0];
      if (i == 2)
        w[21:16] = ECSC_DIV_OFF;
      if (i == 5)
        w[30:28] = ECSC_BW_MAX;
      if (i == 6)
        w[21:16] = ECSC_DIV_MAX;
      if (w[30:28] <= ECSC_BW_MAX)
        bw_e = w[30:28];
      if (i != 3)
        src_e = i[2:0];
      div_e = w[21:16];
      ph_e = w[23];
      wb(1'h1, ECSC_CTRL_ADDR, w, '0);
      @(posedge clk);
      @(negedge clk);
      cfg_chk();
      wb(1'h0, ECSC_CTRL_ADDR, 32'h0, {1'h1, ctrl_exp()});
    end
    // Interrupts: mask, clear, lock loss with and without mask, source change
    wb(1'h1, ECSC_IRQ_MASK_ADDR, 32'h1, '0);
    wb(1'h0, ECSC_IRQ_MASK_ADDR, 32'h0, {1'h1, 32'h1});
    wb(1'h0, ECSC_IRQ_STAT_ADDR, 32'h0, '0);
    wb(1'h0, ECSC_IRQ_STAT_ADDR, 32'h0, {1'h1, 32'h0});
    for (int k = 0; k < 2; k++)
    begin
      drop <= 1'h1;
      @(posedge clk);
      drop <= 1'h0;
      repeat (40) @(posedge clk);
      @(negedge clk);
      chk("irq level", 32'(irq), 32'(k == 0));
      wb(1'h0, ECSC_IRQ_STAT_ADDR, 32'h0, {1'h1, 32'h7});
      @(negedge clk);
      chk("irq cleared", 32'(irq), 32'h0);
      wb(1'h1, ECSC_IRQ_MASK_ADDR, 32'h0, '0);
    end
    {bw_e, src_e, div_e, ph_e} = {3'h0, 3'h1, 6'h00, 1'h0};
    wb(1'h1, ECSC_CTRL_ADDR, 32'h01000000, '0);
    repeat (4) @(posedge clk);
    wb(1'h0, ECSC_IRQ_STAT_ADDR, 32'h0, {1'h1, 32'h8});
    // Unmapped address reads zero and ignores writes
    wb(1'h1, 12'h07C, 32'hFFFFFFFF, '0);
    wb(1'h0, 12'h07C, 32'h0, {1'h1, 32'h0});
    wb(1'h0, ECSC_CTRL_ADDR, 32'h0, {1'h1, ctrl_exp()});
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule
